// ===== rtl/nrz_record_regs.svh
// Timing constants and track layout for the parallel NRZ tape record path
`ifndef NRZ_RECORD_REGS_SVH
`define NRZ_RECORD_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS     50
`define REC_PULSE_NS      1000
`define REC_PULSE_CYCLES  ((`REC_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Track layout, track 1 at index 0
// ----------------------------------------
`define TRACK_COUNT       11
`define WORD_BITS         9
`define TRK_BIT9          0
`define TRK_BIT1          1
`define TRK_BIT2          2
`define TRK_BIT3          3
`define TRK_BIT4          4
`define TRK_CLOCK         5
`define TRK_BIT5          6
`define TRK_BIT6          7
`define TRK_BIT7          8
`define TRK_BIT8          9
`define TRK_FSYNC         10

`endif

// ===== rtl/nrz_record_pkg.sv
// Types shared by the NRZ tape record path
package nrz_record_pkg;
	typedef enum logic {
		PULSE_IDLE,
		PULSE_HIGH
	} pulse_state_t;
endpackage

// ===== rtl/toggle_channel.sv
// One NRZ toggle record channel driving a head with a complementary pair
`timescale 1ns/10ps
module toggle_channel (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Record inputs
	input  wire logic rec_fire,
	input  wire logic data_in,
	// Head drive
	output logic      head_p,
	output logic      head_n
);
	logic state_ff;

	// ----------------------------------------
	// Toggle state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= 1'b0;
		end else if (rec_fire && data_in) begin
			state_ff <= ~state_ff;
		end
	end

	assign head_p = state_ff;
	assign head_n = ~state_ff;
endmodule

// ===== rtl/nrz_tape_record.sv
// Parallel NRZ tape record path: record pulse, frame sync flag, eleven channels
// Notes on behaviour
// - Every strobe that rises while no pulse is running becomes one record pulse that clocks all track channels together.
// - The record pulse is written as a one on the clock track, flipping it once per word.
// - The record pulse starts on the rising edge of the strobe and is a single positive pulse.
// - A rising frame sync edge sets a flag that presents a one to the frame sync channel.
// - After recording the flag clears, so later strobes leave the frame sync track alone.
// - The flag clears on the falling edge of the record pulse, about 1 us after its rise.
// - A channel toggles only when its input is one at the rising edge of a record pulse.
// - Eleven independent toggle channels each drive their own head.
// - Tracks carry bit 9, bits 1-4, clock, bits 5-7, bit 8 and frame sync in that order.
// - Each head gets a true and an inverted drive that are always opposite.
`timescale 1ns/10ps
`include "nrz_record_regs.svh"
module nrz_tape_record #(
	parameter int PULSE_CYCLES = `REC_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	// Digitizer
	input  wire logic                      conv_done,
	input  wire logic [`WORD_BITS-1:0]     word_in,
	// Demultiplexer
	input  wire logic                      frame_sync,
	// Tape heads
	output logic      [`TRACK_COUNT-1:0]   head_p,
	output logic      [`TRACK_COUNT-1:0]   head_n,
	// Status
	output logic                           rec_pulse,
	output logic                           fsync_flag
);
	import nrz_record_pkg::*;

	logic                        rst_meta_ff;
	logic                        rst_sync_ff;
	logic [2:0]                  conv_sync_ff;
	logic [2:0]                  fsync_sync_ff;
	logic                        conv_level_ff;
	logic                        fsync_level_ff;
	logic                        conv_rise;
	logic                        fsync_rise;
	pulse_state_t                pulse_state_ff;
	logic [15:0]                 pulse_cnt_ff;
	logic                        pulse_fall;
	logic                        fsync_ff;
	logic                        rec_fire;
	logic [`TRACK_COUNT-1:0]     track_in;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Level changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			conv_sync_ff   <= 3'h0;
			fsync_sync_ff  <= 3'h0;
			conv_level_ff  <= 1'b0;
			fsync_level_ff <= 1'b0;
		end else begin
			conv_sync_ff  <= {conv_sync_ff[1:0], conv_done};
			fsync_sync_ff <= {fsync_sync_ff[1:0], frame_sync};
			if (conv_sync_ff[1] == conv_sync_ff[2]) begin
				conv_level_ff <= conv_sync_ff[2];
			end
			if (fsync_sync_ff[1] == fsync_sync_ff[2]) begin
				fsync_level_ff <= fsync_sync_ff[2];
			end
		end
	end

	assign conv_rise  = (conv_sync_ff[1] == conv_sync_ff[2]) && conv_sync_ff[2] && !conv_level_ff;
	assign fsync_rise = (fsync_sync_ff[1] == fsync_sync_ff[2]) && fsync_sync_ff[2] && !fsync_level_ff;

	// ----------------------------------------
	// Record pulse generator
	// ----------------------------------------
	// Strobes during a pulse are ignored: one pulse per word
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pulse_state_ff <= PULSE_IDLE;
			pulse_cnt_ff   <= 16'h0000;
		end else begin
			unique case (pulse_state_ff)
				PULSE_IDLE: begin
					if (conv_rise) begin
						pulse_state_ff <= PULSE_HIGH;
						pulse_cnt_ff   <= 16'(PULSE_CYCLES - 1);
					end
				end
				PULSE_HIGH: begin
					if (pulse_cnt_ff == 16'h0000) begin
						pulse_state_ff <= PULSE_IDLE;
					end else begin
						pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
					end
				end
			endcase
		end
	end

	assign rec_pulse  = (pulse_state_ff == PULSE_HIGH);
	assign rec_fire   = conv_rise && (pulse_state_ff == PULSE_IDLE);
	assign pulse_fall = rec_pulse && (pulse_cnt_ff == 16'h0000);

	// ----------------------------------------
	// Frame sync flag
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			fsync_ff <= 1'b0;
		end else if (fsync_rise) begin
			fsync_ff <= 1'b1;
		end else if (pulse_fall) begin
			fsync_ff <= 1'b0;
		end
	end

	assign fsync_flag = fsync_ff;

	// ----------------------------------------
	// Track allocation
	// ----------------------------------------
	always_comb begin
		track_in              = '0;
		track_in[`TRK_BIT9]   = word_in[8];
		track_in[`TRK_BIT1]   = word_in[0];
		track_in[`TRK_BIT2]   = word_in[1];
		track_in[`TRK_BIT3]   = word_in[2];
		track_in[`TRK_BIT4]   = word_in[3];
		track_in[`TRK_CLOCK]  = 1'b1;
		track_in[`TRK_BIT5]   = word_in[4];
		track_in[`TRK_BIT6]   = word_in[5];
		track_in[`TRK_BIT7]   = word_in[6];
		track_in[`TRK_BIT8]   = word_in[7];
		track_in[`TRK_FSYNC]  = fsync_ff;
	end

	// ----------------------------------------
	// Record channels
	// ----------------------------------------
	// Word sampled directly: digitizer holds it stable across the strobe
	for (genvar g = 0; g < `TRACK_COUNT; g++) begin : gen_chan
		toggle_channel u_chan (
			.clk     (clk),
			.rst_b   (rst_sync_ff),
			.rec_fire(rec_fire),
			.data_in (track_in[g]),
			.head_p  (head_p[g]),
			.head_n  (head_n[g])
		);
	end
endmodule

// ===== test/nrz_record_properties.sv
// Port assertions for the NRZ tape record path
`timescale 1ns/10ps
module nrz_record_checker #(
	parameter int PULSE_CYCLES = 20
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        conv_done,
	input wire logic        frame_sync,
	input wire logic [10:0] head_p,
	input wire logic [10:0] head_n,
	input wire logic        rec_pulse,
	input wire logic        fsync_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Counter, since a repeat count cannot take a parameter
	logic [7:0] hi_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) hi_ff <= 8'h00;
		else hi_ff <= rec_pulse ? hi_ff + 8'h01 : 8'h00;
	end
	heads_opposite_a: assert property (head_n == ~head_p) else $error("head pair");
	pulse_length_a: assert property ($fell(rec_pulse) |-> hi_ff == 8'(PULSE_CYCLES)) else $error("pulse len");
	clock_flip_a: assert property ($rose(rec_pulse) |-> head_p[5] != $past(head_p[5])) else $error("clock");
	heads_hold_a: assert property (!$rose(rec_pulse) |-> $stable(head_p)) else $error("head moved");
	sync_track_a: assert property ($rose(rec_pulse) |-> (head_p[10] ^ $past(head_p[10])) == $past(fsync_flag))
		else $error("sync");
	flag_clear_a: assert property ($fell(rec_pulse) |-> !fsync_flag) else $error("flag kept");
	strobe_fire_a: assert property ($rose(conv_done) && !rec_pulse |-> ##[1:6] $rose(rec_pulse))
		else $error("no pulse");
	pulse_cause_a: assert property ($rose(rec_pulse) |-> $past(conv_done)) else $error("stray pulse");
	flag_set_a: assert property ($rose(frame_sync) |-> ##[1:6] fsync_flag) else $error("flag unset");
endmodule
bind nrz_tape_record nrz_record_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_inst (.clk(clk), .rst_b(rst_b),
	.conv_done(conv_done), .frame_sync(frame_sync), .head_p(head_p), .head_n(head_n), .rec_pulse(rec_pulse),
	.fsync_flag(fsync_flag));

// ===== test/digitizer_model.sv
// Digitizer and demultiplexer stand-in
`timescale 1ns/10ps
module digitizer_model (
	input  wire logic clk,
	output logic       conv_done,
	output logic [8:0] word_in,
	output logic       frame_sync
);
	initial begin
		conv_done = 1'b0;
		word_in = 9'h000;
		frame_sync = 1'b0;
	end
	task automatic send(input logic [8:0] w, input logic fs, input int lag);
		frame_sync = fs;
		repeat (3) @(negedge clk);
		frame_sync = 1'b0;
		word_in = w;
		repeat (lag) @(negedge clk);
		conv_done = 1'b1;
		repeat (8) @(negedge clk);
		conv_done = 1'b0;
		// Released word shows no stale copy
		word_in = ~w;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the NRZ tape record path
`timescale 1ns/10ps
module tb;
	logic        clk;
	logic        rst_b;
	logic        conv_done;
	logic [8:0]  word_in;
	logic        frame_sync;
	logic [10:0] head_p;
	logic [10:0] head_n;
	logic        rec_pulse;
	logic        fsync_flag;
	logic [10:0] exp_h;
	logic [15:0] rnd;
	int          err_count;
	int          n_tests;
	nrz_tape_record #(.PULSE_CYCLES(3)) nrz_tape_record_inst (.clk(clk), .rst_b(rst_b), .conv_done(conv_done),
		.word_in(word_in), .frame_sync(frame_sync), .head_p(head_p), .head_n(head_n), .rec_pulse(rec_pulse),
		.fsync_flag(fsync_flag));
	digitizer_model digitizer_model_inst (.clk(clk), .conv_done(conv_done), .word_in(word_in),
		.frame_sync(frame_sync));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [10:0] nxt(input logic [10:0] h, input logic [8:0] w, input logic fs);
		return h ^ {fs, w[7], w[6:4], 1'b1, w[3:0], w[8]};
	endfunction
	task automatic check(input string what, input logic [10:0] e, input logic [10:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic end_sim;
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic word(input logic [8:0] w, input logic fs);
		int i;
		rnd = lfsr(rnd);
		// Lag varies to cover prompt and slow strobes
		digitizer_model_inst.send(w, fs, 10 + int'(rnd[1:0]));
		for (i = 0; i < 40 && rec_pulse !== 1'b0; i++) @(negedge clk);
		if (i == 40) begin
			err_count++;
			end_sim;
		end
		exp_h = nxt(exp_h, w, fs);
		check("head_p", exp_h, head_p);
		check("head_n", ~exp_h, head_n);
		check("fsync_flag", 11'h000, {10'h000, fsync_flag});
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		rnd = 16'h0006;
		exp_h = 11'h000;
		err_count = 0;
		n_tests = 0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		check("reset", 11'h000, head_p);
		check("reset head_n", 11'h7ff, head_n);
		word(9'h1ff, 1'b1);
		word(9'h1ff, 1'b0);
		word(9'h000, 1'b0);
		repeat (40) begin
			rnd = lfsr(rnd);
			word(rnd[8:0], rnd[9]);
		end
		end_sim;
	end
endmodule
